/* File: core/sle_encoder.sv */
// Status lamp encoder: state and diagnostics to three lamps
`timescale 1ns/1ns
`include "sle_map.svh"
module sle_encoder #(
   parameter int BLINK_HALF_CYC = `SLE_BLINK_HALF_CYC
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic lamp_test_i,
   input wire logic internal_act_i,
   input wire logic force_job_i,
   input wire logic energy_pause_i,
   input wire logic maint_demand_i,
   input wire logic diag_event_i,
   input wire logic card_loss_i,
   input wire logic [7:0] op_state_i,
   output logic op_green_o,
   output logic op_yellow_o,
   output logic fault_red_o,
   output logic service_yellow_o,
   output logic single_active_o
);
   logic phase;
   logic fall;
   sle_pkg::sle_lamp_mode_t op_mode, fault_mode, svc_mode;
   sle_pkg::sle_colour_t op_col;
   sle_pkg::sle_red_t red_r, red_nxt;
   logic card_hold_r, card_hold_nxt;
   logic [`SLE_FLASH_CNT_W-1:0] card_cnt_r, card_cnt_nxt;
   logic card_flash_r, card_flash_nxt;
   logic dual;
   logic og_nxt, oy_nxt, fr_nxt, sy_nxt;
   logic og_r, oy_r, fr_r, sy_r, sa_r;

   sle_blink #(
      .HALF_CYC(BLINK_HALF_CYC)
   ) u_blink (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .phase_o(phase),
      .fall_o(fall)
   );

   function automatic logic lamp_on(input sle_pkg::sle_lamp_mode_t m, input logic ph);
      lamp_on = (m == sle_pkg::SLE_LIT) || ((m == sle_pkg::SLE_FLASH) && ph);
   endfunction

   // Redundancy state: card loss drops dual active to single active
   always_comb begin
      red_nxt = red_r;
      dual = (op_state_i == sle_pkg::SLE_ST_DUAL) && (red_r != sle_pkg::SLE_RED_SINGLE);
      case (red_r)
         sle_pkg::SLE_RED_IDLE: begin
            if (dual && card_loss_i) begin
               red_nxt = sle_pkg::SLE_RED_SINGLE; // [RULE11]
            end
         end
         sle_pkg::SLE_RED_SINGLE: begin
            if (op_state_i != sle_pkg::SLE_ST_DUAL) begin
               red_nxt = sle_pkg::SLE_RED_IDLE;
            end
         end
         default: red_nxt = sle_pkg::SLE_RED_IDLE;
      endcase
   end

   // Card loss tracking: three fault flashes and service hold
   always_comb begin
      card_hold_nxt = card_hold_r;
      card_cnt_nxt = card_cnt_r;
      card_flash_nxt = card_flash_r;
      if ((red_r == sle_pkg::SLE_RED_IDLE) && dual && card_loss_i) begin
         card_hold_nxt = 1'b1;
         card_flash_nxt = 1'b1;
         card_cnt_nxt = '0;
      end else begin
         // Only a flash that was really shown counts at the phase fall
         if (card_flash_r && fall && fr_r) begin
            if (card_cnt_r == `SLE_FLASH_CNT_W'(`SLE_CARD_FLASHES - 1)) begin
               card_flash_nxt = 1'b0; // [RULE12]
               card_cnt_nxt = '0;
            end else begin
               card_cnt_nxt = card_cnt_r + `SLE_FLASH_CNT_W'(1);
            end
         end
         if (card_hold_r && (red_r == sle_pkg::SLE_RED_IDLE) &&
             (op_state_i == sle_pkg::SLE_ST_DUAL)) begin
            card_hold_nxt = 1'b0; // [RULE13]
         end
      end
   end

   // Pattern selection by fixed priority
   always_comb begin
      op_mode = sle_pkg::SLE_LIT;
      op_col = sle_pkg::SLE_COL_GREEN;
      fault_mode = sle_pkg::SLE_OFF;
      svc_mode = sle_pkg::SLE_OFF;
      if (lamp_test_i || (op_state_i == sle_pkg::SLE_ST_BOOT)) begin // [RULE16]
         op_mode = sle_pkg::SLE_FLASH; // [RULE1]
         op_col = sle_pkg::SLE_COL_BOTH;
         fault_mode = sle_pkg::SLE_FLASH;
         svc_mode = sle_pkg::SLE_FLASH;
      end else if (op_state_i == sle_pkg::SLE_ST_WARM) begin
         op_mode = sle_pkg::SLE_FLASH; // [RULE6]
         op_col = sle_pkg::SLE_COL_YELLOW;
      end else if (internal_act_i && !dual) begin
         op_mode = sle_pkg::SLE_FLASH; // [RULE3]
         op_col = sle_pkg::SLE_COL_YELLOW;
         svc_mode = sle_pkg::SLE_LIT;
      end else if (op_state_i == sle_pkg::SLE_ST_HALT) begin
         op_col = sle_pkg::SLE_COL_YELLOW; // [RULE2]
         svc_mode = sle_pkg::SLE_LIT;
      end else if (op_state_i == sle_pkg::SLE_ST_PRIM_BOOT) begin
         op_mode = sle_pkg::SLE_FLASH; // [RULE4]
         op_col = sle_pkg::SLE_COL_BOTH;
         svc_mode = sle_pkg::SLE_LIT;
      end else if (op_state_i == sle_pkg::SLE_ST_BACK_ALIGN) begin
         op_mode = sle_pkg::SLE_FLASH; // [RULE5]
         op_col = sle_pkg::SLE_COL_BOTH;
         fault_mode = sle_pkg::SLE_FLASH;
         svc_mode = sle_pkg::SLE_LIT;
      end else if (diag_event_i && maint_demand_i) begin
         fault_mode = sle_pkg::SLE_FLASH; // [RULE10]
         svc_mode = sle_pkg::SLE_LIT;
      end else if (diag_event_i && dual) begin
         fault_mode = sle_pkg::SLE_FLASH; // [RULE9]
      end else if (maint_demand_i || force_job_i || energy_pause_i ||
                   (op_state_i == sle_pkg::SLE_ST_PRIM_ALIGN)) begin
         svc_mode = sle_pkg::SLE_LIT; // [RULE7]
      end else begin
         op_mode = sle_pkg::SLE_LIT; // [RULE8]
      end
      if (card_flash_r && !lamp_test_i && (op_state_i != sle_pkg::SLE_ST_BOOT)) begin
         fault_mode = sle_pkg::SLE_FLASH; // [RULE12]
      end
      if (card_hold_r && !dual && (svc_mode == sle_pkg::SLE_OFF)) begin
         svc_mode = sle_pkg::SLE_LIT; // [RULE13]
      end
      if (!(dual && !maint_demand_i) && (svc_mode == sle_pkg::SLE_OFF) &&
          (op_state_i != sle_pkg::SLE_ST_WARM)) begin
         svc_mode = sle_pkg::SLE_LIT; // [RULE14]
      end
   end

   // Lamp drive from the shared blink phase
   always_comb begin
      og_nxt = lamp_on(op_mode, phase) && (op_col != sle_pkg::SLE_COL_YELLOW); // [RULE15]
      oy_nxt = lamp_on(op_mode, phase) && (op_col != sle_pkg::SLE_COL_GREEN);
      fr_nxt = lamp_on(fault_mode, phase);
      sy_nxt = lamp_on(svc_mode, phase);
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         red_r <= sle_pkg::SLE_RED_IDLE;
         card_hold_r <= 1'b0;
         card_cnt_r <= '0;
         card_flash_r <= 1'b0;
         og_r <= 1'b0;
         oy_r <= 1'b0;
         fr_r <= 1'b0;
         sy_r <= 1'b0;
         sa_r <= 1'b0;
      end else if (ce_i) begin
         red_r <= red_nxt;
         card_hold_r <= card_hold_nxt;
         card_cnt_r <= card_cnt_nxt;
         card_flash_r <= card_flash_nxt;
         og_r <= og_nxt;
         oy_r <= oy_nxt;
         fr_r <= fr_nxt;
         sy_r <= sy_nxt;
         sa_r <= (red_nxt == sle_pkg::SLE_RED_SINGLE);
      end
   end

   assign op_green_o = og_r;
   assign op_yellow_o = oy_r;
   assign fault_red_o = fr_r;
   assign service_yellow_o = sy_r;
   assign single_active_o = sa_r;
endmodule

/* File: core/sle_map.svh */
// Constants and timing counts for the status lamp encoder
// Function
// RULE1 - Boot or lamp test: flash all three lamps
// RULE2 - Halted: operating yellow, service yellow steady
// RULE3 - Internal activity: operating flashes yellow, service lit
// RULE4 - Primary boot phase: operating flashes, service lit
// RULE5 - Backup aligning: operating and fault flash
// RULE6 - Warm restart: operating flashes yellow, others dark; code still lights service and flashes fault after card loss
// RULE7 - Maintenance or aligning/forcing/pause: green, service lit
// RULE8 - Clean run: operating green, others dark
// RULE9 - Event in dual active: fault flashes
// RULE10 - Event plus maintenance: fault flashes, service lit
// RULE11 - Card loss in dual active: go single active
// RULE12 - Card loss: fault flashes exactly three times
// RULE13 - Card loss: service lit until dual active
// RULE14 - Service dark only in dual active with no demand, or in warm restart
// RULE15 - One shared blink timebase keeps lamps in phase
// RULE16 - Fixed priority selects one pattern
`ifndef SLE_MAP_SVH
`define SLE_MAP_SVH
`define SLE_CLK_HZ 50000000
`define SLE_BLINK_HALF_MS 250
`define SLE_BLINK_HALF_CYC ((`SLE_CLK_HZ / 1000) * `SLE_BLINK_HALF_MS)
`define SLE_BLINK_W 24
`define SLE_CARD_FLASHES 3
`define SLE_FLASH_CNT_W 2
`endif

/* File: core/sle_pkg.sv */
// Types for the status lamp encoder
package sle_pkg;
   typedef enum logic [1:0] {
      SLE_OFF = 2'h0,
      SLE_LIT = 2'h1,
      SLE_FLASH = 2'h2
   } sle_lamp_mode_t;
   typedef enum logic [1:0] {
      SLE_COL_YELLOW = 2'h0,
      SLE_COL_GREEN = 2'h1,
      SLE_COL_BOTH = 2'h2
   } sle_colour_t;
   typedef enum logic [7:0] {
      SLE_ST_BOOT = 8'h01,
      SLE_ST_HALT = 8'h02,
      SLE_ST_PRIM_BOOT = 8'h04,
      SLE_ST_BACK_ALIGN = 8'h08,
      SLE_ST_WARM = 8'h10,
      SLE_ST_PRIM_ALIGN = 8'h20,
      SLE_ST_PRIM_RUN = 8'h40,
      SLE_ST_DUAL = 8'h80
   } sle_opstate_t;
   typedef enum logic [1:0] {
      SLE_RED_IDLE = 2'h1,
      SLE_RED_SINGLE = 2'h2
   } sle_red_t;
endpackage

/* File: core/sle_blink.sv */
// Shared blink timebase for all lamps
`timescale 1ns/1ns
`include "sle_map.svh"
module sle_blink #(
   parameter int HALF_CYC = `SLE_BLINK_HALF_CYC
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   output logic phase_o,
   output logic fall_o
);
   logic [`SLE_BLINK_W-1:0] cnt_r, cnt_nxt;
   logic phase_r, phase_nxt;
   logic fall_r, fall_nxt;
   always_comb begin
      cnt_nxt = cnt_r + `SLE_BLINK_W'(1);
      phase_nxt = phase_r;
      fall_nxt = 1'b0;
      if (cnt_r == `SLE_BLINK_W'(HALF_CYC - 1)) begin // [RULE15]
         cnt_nxt = '0;
         phase_nxt = ~phase_r;
         fall_nxt = phase_r;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         cnt_r <= '0;
         phase_r <= 1'b0;
         fall_r <= 1'b0;
      end else if (ce_i) begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
         fall_r <= fall_nxt;
      end
   end
   assign phase_o = phase_r;
   assign fall_o = fall_r;
endmodule

/* File: testbench/sle_encoder_asserts.sv */
// Port checks for the status lamp encoder
`timescale 1ns/1ns
module sle_encoder_asserts (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic lamp_test_i,
   input wire logic internal_act_i,
   input wire logic force_job_i,
   input wire logic energy_pause_i,
   input wire logic maint_demand_i,
   input wire logic diag_event_i,
   input wire logic card_loss_i,
   input wire logic [7:0] op_state_i,
   input wire logic op_green_o,
   input wire logic op_yellow_o,
   input wire logic fault_red_o,
   input wire logic service_yellow_o,
   input wire logic single_active_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   rst_out_a: assert property (disable iff (1'b0) ce_i && !reset_n_i |=> !op_green_o &&
      !op_yellow_o && !fault_red_o && !service_yellow_o && !single_active_o) else $error("reset");
   test_phase_a: assert property (ce_i && lamp_test_i |=> op_green_o == op_yellow_o &&
      op_yellow_o == fault_red_o && fault_red_o == service_yellow_o) else $error("test");
   halt_lamps_a: assert property (ce_i && op_state_i == 8'h02 && !lamp_test_i &&
      !internal_act_i |=> op_yellow_o && !op_green_o && service_yellow_o) else $error("halt");
   warm_dark_a: assert property (ce_i && op_state_i == 8'h10 && !lamp_test_i
      |=> !op_green_o && !service_yellow_o) else $error("warm");
   clean_run_a: assert property (ce_i && op_state_i == 8'h80 && !single_active_o &&
      !card_loss_i && !lamp_test_i && !maint_demand_i && !force_job_i && !energy_pause_i
      |=> op_green_o && !op_yellow_o && !service_yellow_o) else $error("clean run");
   service_lit_a: assert property (ce_i && !lamp_test_i &&
      op_state_i inside {8'h02, 8'h04, 8'h08, 8'h20, 8'h40} |=> service_yellow_o)
      else $error("service");
   single_set_a: assert property (ce_i && op_state_i == 8'h80 && card_loss_i
      |=> single_active_o) else $error("single set");
   single_clr_a: assert property (ce_i && single_active_o && op_state_i != 8'h80
      |=> !single_active_o) else $error("single clear");
   cover property (single_active_o);
   cover property (ce_i && lamp_test_i);
   cover property (op_green_o && service_yellow_o);
endmodule
bind sle_encoder sle_encoder_asserts u_chk (.*);

/* File: testbench/sle_lamp_panel.sv */
// Front panel model counting fault lamp flashes
`timescale 1ns/1ns
module sle_lamp_panel (
   input wire logic mclk_i,
   input wire logic fault_red_i,
   output logic [7:0] fault_flashes_o
);
   logic last_r = 1'b0;
   initial fault_flashes_o = 8'h00;
   always @(posedge mclk_i) begin
      last_r <= fault_red_i;
      if (fault_red_i && !last_r) fault_flashes_o <= fault_flashes_o + 8'h01;
   end
endmodule

/* File: testbench/sle_encoder_tb.sv */
// Self-checking bench for the status lamp encoder
`timescale 1ns/1ns
module sle_encoder_tb;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic lamp_test_i = 1'b0;
   logic internal_act_i = 1'b0;
   logic force_job_i = 1'b0;
   logic energy_pause_i = 1'b0;
   logic maint_demand_i = 1'b0;
   logic diag_event_i = 1'b0;
   logic card_loss_i = 1'b0;
   logic [7:0] op_state_i = 8'h40;
   logic op_green_o, op_yellow_o, fault_red_o, service_yellow_o, single_active_o;
   logic [7:0] flashes;
   logic [4:0] seen;
   localparam int HALF = 4;
   int n_errors = 0;
   int comparisons = 0;
   assign seen = {op_green_o, op_yellow_o, fault_red_o, service_yellow_o, single_active_o};
   sle_encoder #(.BLINK_HALF_CYC(HALF)) uut (.*);
   sle_lamp_panel panel (.mclk_i(mclk_i), .fault_red_i(fault_red_o), .fault_flashes_o(flashes));
   initial begin
      forever #10 mclk_i = ~mclk_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic go(input logic [7:0] st, input logic [6:0] f);
      @(posedge mclk_i);
      op_state_i <= st;
      {lamp_test_i, internal_act_i, force_job_i, energy_pause_i, maint_demand_i,
         diag_event_i, card_loss_i} <= f;
   endtask
   // Watch one full blink period: steady lamps never change, flashing ones do
   task automatic lamps(input logic [4:0] lit, input logic [4:0] flash);
      logic [4:0] ever;
      logic [4:0] steady;
      ever = 5'h00;
      steady = 5'h1F;
      @(posedge mclk_i);
      repeat (2 * HALF) begin
         @(posedge mclk_i);
         #1;
         ever = ever | seen;
         steady = steady & seen;
      end
      check({3'h0, steady}, {3'h0, lit});
      check({3'h0, ever}, {3'h0, lit | flash});
   endtask
   task automatic boot_and_test();
      go(8'h01, 7'h00); lamps(5'h00, 5'h1E);
      go(8'h80, 7'h46); lamps(5'h00, 5'h1E);
   endtask
   task automatic transitional();
      go(8'h02, 7'h04); lamps(5'h0A, 5'h00);
      go(8'h04, 7'h00); lamps(5'h02, 5'h18);
      go(8'h08, 7'h00); lamps(5'h02, 5'h1C);
      go(8'h40, 7'h20); lamps(5'h02, 5'h08);
      go(8'h80, 7'h20); lamps(5'h10, 5'h00);
      go(8'h10, 7'h24); lamps(5'h00, 5'h08);
   endtask
   task automatic run_states();
      go(8'h80, 7'h00); lamps(5'h10, 5'h00);
      go(8'h80, 7'h04); lamps(5'h12, 5'h00);
      go(8'h20, 7'h00); lamps(5'h12, 5'h00);
      go(8'h80, 7'h10); lamps(5'h12, 5'h00);
      go(8'h80, 7'h08); lamps(5'h12, 5'h00);
      go(8'h80, 7'h02); lamps(5'h10, 5'h04);
      go(8'h80, 7'h06); lamps(5'h12, 5'h04);
      go(8'h40, 7'h00); lamps(5'h12, 5'h00);
   endtask
   task automatic card_loss();
      logic [7:0] base;
      base = flashes;
      go(8'h80, 7'h01); lamps(5'h13, 5'h04);
      repeat (8 * HALF) @(posedge mclk_i);
      check(flashes - base, 8'h03);
      go(8'h80, 7'h00); lamps(5'h13, 5'h00);
      go(8'h40, 7'h00); lamps(5'h12, 5'h00);
      go(8'h80, 7'h00); lamps(5'h10, 5'h00);
   endtask
   // Freeze while the fault lamp flashes: no new flash may appear
   task automatic freeze();
      logic [7:0] base;
      go(8'h08, 7'h00);
      repeat (2 * HALF) @(posedge mclk_i);
      ce_i <= 1'b0;
      op_state_i <= 8'h02;
      repeat (2) @(posedge mclk_i);
      base = flashes;
      repeat (4 * HALF) @(posedge mclk_i);
      check(flashes - base, 8'h00);
      ce_i <= 1'b1;
      lamps(5'h0A, 5'h00);
   endtask
   task automatic complete_run();
      if (n_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      boot_and_test();
      transitional();
      run_states();
      card_loss();
      freeze();
      complete_run();
   end
   initial begin
      #20000;
      n_errors++;
      complete_run();
   end
endmodule
